// file: asf_pkg.sv
// Purpose: constants for the converter serial control and result queue
// Assumes: 20 MHz system clock, nominal 4.4 MHz internal conversion clock
// Notes:   command byte layout, clock modes, timing counts
package asf_pkg;
   localparam int CLK_HZ     = 20_000_000;
   localparam int OSC_HZ     = 4_400_000;
   localparam int OSC_DIV    = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;
   localparam int ACQ_NS     = 1400;
   localparam int ACQ_CYC    = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int SAR_TICKS  = 13;
   localparam int EXT_ACQ_ED = 4;
   localparam int EXT_SAR_ED = 12;
   localparam int RES_W      = 12;
   localparam int FIFO_DEPTH = 16;
   // command byte type bits
   localparam int CONV_BIT   = 7;
   localparam int SETUP_BIT  = 6;
   localparam int AVG_BIT    = 5;
   localparam int RST_BIT    = 4;
   // field positions
   localparam int CKSEL_HI   = 5;
   localparam int CKSEL_LO   = 4;
   localparam int DIFF_HI    = 1;
   localparam int DIFF_LO    = 0;
   localparam int CHSEL_HI   = 6;
   localparam int CHSEL_LO   = 3;
   localparam int SCAN_HI    = 2;
   localparam int SCAN_LO    = 1;
   localparam int TEMP_BIT   = 0;
   localparam int NSCAN_HI   = 1;
   localparam int NSCAN_LO   = 0;
   localparam int FIFO_ONLY  = 3;
   // clock modes
   localparam logic [1:0] MODE_PIN_SCAN = 2'h0;
   localparam logic [1:0] MODE_PIN_EACH = 2'h1;
   localparam logic [1:0] MODE_SERIAL   = 2'h2;
   localparam logic [1:0] MODE_EXT      = 2'h3;
   // scan modes
   localparam logic [1:0] SCAN_UP   = 2'h0;
   localparam logic [1:0] SCAN_DOWN = 2'h1;
   localparam logic [1:0] SCAN_REP  = 2'h2;
   localparam logic [1:0] SCAN_ONCE = 2'h3;
   // reset values
   localparam logic [7:0] PAIR_RST  = 8'h00;
   localparam logic [1:0] NSCAN_RST = 2'h0;
   typedef enum {CV_IDLE, CV_TRACK, CV_CONV} asf_conv_t;
endpackage

// file: asf_top.sv
// Purpose: serial command port, clock modes, conversion sequencer, result queue
// Assumes: serial pins and conversion start pin are asynchronous to CLK_I
// Notes:   serial clock must be slow against CLK_I (bench uses 400 ns)
`timescale 1ns/1ps
module asf_top (
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   // serial port
   input  wire logic        CS_N_I,
   input  wire logic        SCLK_I,
   input  wire logic        DIN_I,
   output logic             DOUT_O,
   output logic             DOUT_OE_O,
   // conversion control
   input  wire logic        CONVERSION_START_PIN_N_I,
   output logic             EOC_N_O,
   // analog core
   input  wire logic [11:0] ANALOG_CODE_I,
   input  wire logic        ANALOG_NEG_I,
   input  wire logic [11:0] TEMP_CODE_I,
   output logic [3:0]       CONV_CHAN_O,
   output logic             CONV_DIFF_O,
   output logic             CONV_TEMP_O,
   output logic             TRACK_O,
   output logic             OSC_EN_O
);
   // ***************************************************
   // input synchronisers and edges
   // ***************************************************
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] sync3_reg;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1_reg <= 4'hF;
         sync2_reg <= 4'hF;
         sync3_reg <= 4'hF;
      end else begin
         sync1_reg <= {CONVERSION_START_PIN_N_I, DIN_I, SCLK_I, CS_N_I};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   wire cs_n_s    = sync2_reg[0];
   wire din_s     = sync2_reg[2];
   wire cs_fall   = sync3_reg[0] & ~sync2_reg[0];
   wire sclk_rise = ~cs_n_s & ~sync3_reg[1] & sync2_reg[1];
   wire sclk_fall = ~cs_n_s & sync3_reg[1] & ~sync2_reg[1];
   wire sclk_rise_any = ~sync3_reg[1] & sync2_reg[1];
   wire cnv_fall  = sync3_reg[3] & ~sync2_reg[3];
   wire cnv_rise  = ~sync3_reg[3] & sync2_reg[3];

   // ***************************************************
   // command receiver
   // ***************************************************
   logic [6:0] rx_sh_reg;
   logic [2:0] rx_cnt_reg;
   logic       pair_pend_reg;
   logic       pair_bip_reg;
   logic [1:0] mode_reg;
   logic [7:0] uni_reg;
   logic [7:0] bip_reg;
   logic [3:0] chsel_reg;
   logic [1:0] scan_reg;
   logic       temp_req_reg;
   logic [1:0] nscan_reg;
   wire        byte_done = sclk_rise & (rx_cnt_reg == 3'h7);
   wire [7:0]  rx_byte   = {rx_sh_reg, din_s};
   wire        is_pair   = byte_done & pair_pend_reg;
   wire        is_conv   = byte_done & ~pair_pend_reg & rx_byte[asf_pkg::CONV_BIT];
   wire        is_setup  = byte_done & ~pair_pend_reg & (rx_byte[7:6] == 2'h1);
   wire        is_avg    = byte_done & ~pair_pend_reg & (rx_byte[7:5] == 3'h1);
   wire        is_rst    = byte_done & ~pair_pend_reg & (rx_byte[7:4] == 4'h1);
   wire        rst_all   = is_rst & ~rx_byte[asf_pkg::FIFO_ONLY];
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_sh_reg     <= 7'h00;
         rx_cnt_reg    <= 3'h0;
         pair_pend_reg <= 1'b0;
         pair_bip_reg  <= 1'b0;
         mode_reg      <= asf_pkg::MODE_SERIAL;
         uni_reg       <= asf_pkg::PAIR_RST;
         bip_reg       <= asf_pkg::PAIR_RST;
         chsel_reg     <= 4'h0;
         scan_reg      <= asf_pkg::SCAN_ONCE;
         temp_req_reg  <= 1'b0;
         nscan_reg     <= asf_pkg::NSCAN_RST;
      end else begin
         if (cs_fall) begin
            rx_cnt_reg    <= 3'h0;
            pair_pend_reg <= 1'b0;
         end else if (sclk_rise) begin
            rx_sh_reg  <= rx_byte[6:0];
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
         end
         if (is_pair) begin
            pair_pend_reg <= 1'b0;
            if (pair_bip_reg) bip_reg <= rx_byte;
            else uni_reg <= rx_byte;
         end
         if (is_conv) begin
            chsel_reg    <= rx_byte[asf_pkg::CHSEL_HI:asf_pkg::CHSEL_LO];
            scan_reg     <= rx_byte[asf_pkg::SCAN_HI:asf_pkg::SCAN_LO];
            temp_req_reg <= rx_byte[asf_pkg::TEMP_BIT];
         end
         if (is_setup) begin
            mode_reg      <= rx_byte[asf_pkg::CKSEL_HI:asf_pkg::CKSEL_LO];
            pair_pend_reg <= rx_byte[asf_pkg::DIFF_HI];
            pair_bip_reg  <= rx_byte[asf_pkg::DIFF_LO];
         end
         if (is_avg) nscan_reg <= rx_byte[asf_pkg::NSCAN_HI:asf_pkg::NSCAN_LO];
         if (rst_all) begin
            mode_reg  <= asf_pkg::MODE_SERIAL;
            uni_reg   <= asf_pkg::PAIR_RST;
            bip_reg   <= asf_pkg::PAIR_RST;
            nscan_reg <= asf_pkg::NSCAN_RST;
         end
      end
   end

   // ***************************************************
   // internal oscillator enable
   // ***************************************************
   logic [2:0] osc_cnt_reg;
   wire        osc_run  = (mode_reg != asf_pkg::MODE_EXT);
   wire        osc_tick = osc_run & (osc_cnt_reg == 3'(asf_pkg::OSC_DIV - 1));
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) osc_cnt_reg <= 3'h0;
      else if (!osc_run || osc_tick) osc_cnt_reg <= 3'h0;
      else osc_cnt_reg <= osc_cnt_reg + 3'h1;
   end

   // ***************************************************
   // conversion sequencer
   // ***************************************************
   asf_pkg::asf_conv_t st_reg;
   logic [5:0] tmr_reg;
   logic [3:0] ch_reg;
   logic [3:0] last_reg;
   logic [4:0] rep_reg;
   logic       tpend_reg;
   logic       seq_open_reg;
   logic       eoc_n_reg;
   wire        ext_mode  = (mode_reg == asf_pkg::MODE_EXT);
   wire        pin_mode  = ~mode_reg[1];
   // outside the pin modes a conversion command starts on the edge that also stores its fields
   wire [3:0]  chsel_now = is_conv ? rx_byte[asf_pkg::CHSEL_HI:asf_pkg::CHSEL_LO] : chsel_reg;
   wire [1:0]  scan_now  = is_conv ? rx_byte[asf_pkg::SCAN_HI:asf_pkg::SCAN_LO] : scan_reg;
   wire        temp_now  = is_conv ? rx_byte[asf_pkg::TEMP_BIT] : temp_req_reg;
   wire [1:0]  scan_eff  = ext_mode ? asf_pkg::SCAN_ONCE : scan_now;
   wire        start_req = pin_mode ? cnv_fall : is_conv;
   wire        idle      = (st_reg == asf_pkg::CV_IDLE);
   wire        load_seq  = idle & start_req & ~seq_open_reg;
   wire [2:0]  pair_idx  = 3'(7 - ch_reg[3:1]);
   wire        ch_bip    = bip_reg[pair_idx];
   wire        ch_diff   = uni_reg[pair_idx] | ch_bip;
   wire [3:0]  ch_drive  = ch_diff ? {ch_reg[3:1], 1'b0} : ch_reg;
   wire [4:0]  ch_step   = {1'b0, ch_drive} + (ch_diff ? 5'h02 : 5'h01);
   wire        seq_end   = (rep_reg <= 5'h01) & (ch_step > {1'b0, last_reg});
   wire        tick      = ext_mode ? sclk_rise_any : osc_tick;
   wire        trk_done  = (mode_reg == asf_pkg::MODE_PIN_EACH) ? cnv_rise :
                           ext_mode ? (tmr_reg == 6'(asf_pkg::EXT_ACQ_ED)) :
                           (tmr_reg == 6'(asf_pkg::ACQ_CYC));
   wire [5:0]  conv_len  = ext_mode ? 6'(asf_pkg::EXT_SAR_ED) : 6'(asf_pkg::SAR_TICKS);
   wire        conv_done = (st_reg == asf_pkg::CV_CONV) & tick & (tmr_reg == conv_len - 6'h01);
   wire        push_ch   = conv_done & ~tpend_reg;
   wire        each_mode = (mode_reg == asf_pkg::MODE_PIN_EACH);
   wire        eoc_set   = conv_done & (each_mode | (~tpend_reg & seq_end));
   wire [11:0] unip_code = ANALOG_NEG_I ? 12'h000 : ANALOG_CODE_I;
   wire [11:0] ch_result = (ch_diff & ch_bip) ? {~ANALOG_CODE_I[11], ANALOG_CODE_I[10:0]}
                                              : unip_code;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_reg       <= asf_pkg::CV_IDLE;
         tmr_reg      <= 6'h00;
         ch_reg       <= 4'h0;
         last_reg     <= 4'h0;
         rep_reg      <= 5'h01;
         tpend_reg    <= 1'b0;
         seq_open_reg <= 1'b0;
      end else begin
         case (st_reg)
            asf_pkg::CV_IDLE: begin
               tmr_reg <= 6'h00;
               if (load_seq) begin
                  ch_reg    <= (scan_eff == asf_pkg::SCAN_UP) ? 4'h0 : chsel_now;
                  last_reg  <= (scan_eff == asf_pkg::SCAN_UP) ? chsel_now :
                               (scan_eff == asf_pkg::SCAN_DOWN) ? 4'hF : chsel_now;
                  rep_reg   <= (scan_eff == asf_pkg::SCAN_REP) ? {1'b0, nscan_reg, 2'h0} + 5'h04 : 5'h01;
                  tpend_reg <= temp_now;
               end
               if (idle & start_req) begin
                  seq_open_reg <= 1'b1;
                  st_reg       <= asf_pkg::CV_TRACK;
               end
            end
            asf_pkg::CV_TRACK: begin
               if (trk_done) begin
                  tmr_reg <= 6'h00;
                  st_reg  <= asf_pkg::CV_CONV;
               end else if (ext_mode ? sclk_rise_any : 1'b1) begin
                  tmr_reg <= tmr_reg + 6'h01;
               end
            end
            asf_pkg::CV_CONV: begin
               if (conv_done) begin
                  tmr_reg <= 6'h00;
                  if (tpend_reg) tpend_reg <= 1'b0;
                  else if (rep_reg > 5'h01) rep_reg <= rep_reg - 5'h01;
                  else ch_reg <= ch_step[3:0];
                  if (~tpend_reg & seq_end) seq_open_reg <= 1'b0;
                  st_reg <= (each_mode | (~tpend_reg & seq_end)) ? asf_pkg::CV_IDLE : asf_pkg::CV_TRACK;
               end else if (tick) begin
                  tmr_reg <= tmr_reg + 6'h01;
               end
            end
            default: st_reg <= asf_pkg::CV_IDLE;
         endcase
         if (is_setup) seq_open_reg <= 1'b0;
      end
   end

   // ***************************************************
   // end-of-conversion flag and core outputs
   // ***************************************************
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         eoc_n_reg   <= 1'b1;
         CONV_CHAN_O <= 4'h0;
         CONV_DIFF_O <= 1'b0;
         CONV_TEMP_O <= 1'b0;
         TRACK_O     <= 1'b0;
         OSC_EN_O    <= 1'b0;
      end else begin
         if (ext_mode) eoc_n_reg <= 1'b1;
         else if (eoc_set) eoc_n_reg <= 1'b0;
         else if (cs_fall | (pin_mode & cnv_fall)) eoc_n_reg <= 1'b1;
         CONV_CHAN_O <= ch_drive;
         CONV_DIFF_O <= ch_diff;
         CONV_TEMP_O <= tpend_reg;
         TRACK_O     <= (st_reg == asf_pkg::CV_TRACK);
         OSC_EN_O    <= osc_run;
      end
   end
   assign EOC_N_O = eoc_n_reg;

   // ***************************************************
   // result queue and temperature slot
   // ***************************************************
   logic [11:0] fifo_mem [asf_pkg::FIFO_DEPTH];
   logic [3:0]  wr_ptr_reg;
   logic [3:0]  rd_ptr_reg;
   logic [4:0]  cnt_reg;
   logic [11:0] temp_reg;
   logic        temp_vld_reg;
   logic        pop_fifo;
   logic        pop_temp;
   wire         fifo_full = (cnt_reg == 5'(asf_pkg::FIFO_DEPTH));
   wire         fifo_clr  = is_rst;
   wire         overwrite = push_ch & fifo_full & ~pop_fifo;
   always_ff @(posedge CLK_I) begin
      if (push_ch) fifo_mem[wr_ptr_reg] <= ch_result;
   end
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wr_ptr_reg   <= 4'h0;
         rd_ptr_reg   <= 4'h0;
         cnt_reg      <= 5'h00;
         temp_reg     <= 12'h000;
         temp_vld_reg <= 1'b0;
      end else begin
         if (fifo_clr) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            cnt_reg    <= 5'h00;
         end else begin
            if (push_ch) wr_ptr_reg <= wr_ptr_reg + 4'h1;
            if (pop_fifo | overwrite) rd_ptr_reg <= rd_ptr_reg + 4'h1;
            if (push_ch & ~pop_fifo & ~fifo_full) cnt_reg <= cnt_reg + 5'h01;
            else if (pop_fifo & ~push_ch) cnt_reg <= cnt_reg - 5'h01;
         end
         if (conv_done & tpend_reg) begin
            temp_reg     <= TEMP_CODE_I;
            temp_vld_reg <= 1'b1;
         end else if (pop_temp | fifo_clr) begin
            temp_vld_reg <= 1'b0;
         end
      end
   end

   // ***************************************************
   // data out shifter
   // ***************************************************
   logic [7:0] tx_sh_reg;
   logic [7:0] lo_hold_reg;
   logic       lo_next_reg;
   logic       lo_temp_reg;
   logic       cur_lo_reg;
   logic       hi_vld_reg;
   logic       pend_reg;
   logic       seen_rise_reg;
   logic [2:0] fall_cnt_reg;
   logic       oe_reg;
   wire        fifo_any  = (cnt_reg != 5'h00);
   wire        load_evt  = cs_fall | (sclk_fall & seen_rise_reg & (fall_cnt_reg == 3'h7));
   wire        load_lo   = load_evt & lo_next_reg;
   wire        load_hi   = load_evt & ~lo_next_reg;
   // a loaded byte counts as read only once the host clocks its first bit
   wire        commit    = sclk_rise & pend_reg & ~load_evt;
   wire        drop_lo   = fifo_clr | (overwrite & ~lo_temp_reg);
   wire [11:0] hi_src    = temp_vld_reg ? temp_reg : fifo_mem[rd_ptr_reg];
   wire        hi_ok     = temp_vld_reg | fifo_any;
   assign pop_temp = commit & cur_lo_reg & lo_temp_reg;
   assign pop_fifo = commit & cur_lo_reg & ~lo_temp_reg & fifo_any;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tx_sh_reg     <= 8'h00;
         lo_hold_reg   <= 8'h00;
         lo_next_reg   <= 1'b0;
         lo_temp_reg   <= 1'b0;
         cur_lo_reg    <= 1'b0;
         hi_vld_reg    <= 1'b0;
         pend_reg      <= 1'b0;
         seen_rise_reg <= 1'b0;
         fall_cnt_reg  <= 3'h0;
         oe_reg        <= 1'b0;
      end else begin
         oe_reg <= ~cs_n_s;
         if (cs_fall) begin
            seen_rise_reg <= 1'b0;
            fall_cnt_reg  <= 3'h0;
         end else if (sclk_rise) begin
            seen_rise_reg <= 1'b1;
         end else if (sclk_fall & seen_rise_reg) begin
            fall_cnt_reg <= fall_cnt_reg + 3'h1;
            if (fall_cnt_reg != 3'h7) tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
         if (load_lo) begin
            tx_sh_reg  <= lo_hold_reg;
            cur_lo_reg <= 1'b1;
            pend_reg   <= 1'b1;
         end else if (load_hi) begin
            tx_sh_reg   <= hi_ok ? {4'h0, hi_src[11:8]} : 8'h00;
            lo_hold_reg <= hi_src[7:0];
            lo_temp_reg <= temp_vld_reg;
            hi_vld_reg  <= hi_ok;
            cur_lo_reg  <= 1'b0;
            pend_reg    <= 1'b1;
         end else if (commit) begin
            pend_reg    <= 1'b0;
            lo_next_reg <= ~cur_lo_reg & hi_vld_reg;
         end
         if (drop_lo) lo_next_reg <= 1'b0;
      end
   end
   assign DOUT_O    = tx_sh_reg[7];
   assign DOUT_OE_O = oe_reg;

endmodule // asf_top

// file: asf_properties.sv
// Purpose: concurrent checks on the converter control pins
// Assumes: one clock domain CLK_I, RST_N_I active low
// Notes:   bound to asf_top from the tb file
`timescale 1ns/1ps
module asf_properties (
   // clock and reset
   input wire logic       CLK_I,
   input wire logic       RST_N_I,
   // watched pins
   input wire logic       CS_N_I,
   input wire logic       SCLK_I,
   input wire logic       CONVERSION_START_PIN_N_I,
   input wire logic       DOUT_O,
   input wire logic       DOUT_OE_O,
   input wire logic       EOC_N_O,
   input wire logic [3:0] CONV_CHAN_O,
   input wire logic       CONV_DIFF_O,
   input wire logic       TRACK_O,
   input wire logic       OSC_EN_O
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   a_oe_idle: assert property (CS_N_I [*4] |-> !DOUT_OE_O)
      else $error("data out driven while deselected");
   a_oe_rise: assert property ($rose(DOUT_OE_O) |-> !CS_N_I && $past(!CS_N_I, 2))
      else $error("data out enabled without select");
   a_dout_edge: assert property (DOUT_OE_O && $past(DOUT_OE_O) && $changed(DOUT_O) |-> !SCLK_I)
      else $error("data out changed outside a falling serial clock");
   a_eoc_release: assert property ($fell(CS_N_I) |-> ##[1:4] EOC_N_O)
      else $error("end flag not released by select fall");
   a_eoc_ext: assert property (!OSC_EN_O && $past(!OSC_EN_O) |-> EOC_N_O)
      else $error("end flag low in serial clocked mode");
   a_track_eoc: assert property (TRACK_O [*3] |-> EOC_N_O)
      else $error("end flag low while tracking");
   a_diff_even: assert property (CONV_DIFF_O |-> !CONV_CHAN_O[0])
      else $error("differential pair on odd channel");
   a_eoc_holds: assert property (!EOC_N_O && CS_N_I && $past(CS_N_I, 4) && CONVERSION_START_PIN_N_I
      && $past(CONVERSION_START_PIN_N_I, 4) |=> !EOC_N_O)
      else $error("end flag released without cause");
endmodule // asf_properties

// file: asf_host.sv
// Purpose: host serial master model, clock idles low, phase 0
// Assumes: serial clock period 8 CLK_I (400 ns)
// Notes:   bytes after the second one are sent as zero
`timescale 1ns/1ps
module asf_host (
   // clock
   input wire logic CLK_I,
   // serial pins
   output logic     CS_N_O,
   output logic     SCLK_O,
   output logic     DIN_O,
   input wire logic DOUT_I,
   input wire logic DOUT_OE_I
);
   logic [7:0] rx_buf [0:1];
   // ****************************************
   // frame driver
   // ****************************************
   initial begin
      CS_N_O = 1'b1;
      SCLK_O = 1'b0;
      DIN_O = 1'b0;
   end
   task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n);
      logic [7:0] tx;
      @(posedge CLK_I);
      CS_N_O <= 1'b0;
      for (int b = 0; b < n; b++) begin
         tx = (b == 0) ? b0 : ((b == 1) ? b1 : 8'h00);
         for (int i = 7; i >= 0; i--) begin
            DIN_O <= tx[i];
            repeat (4) @(posedge CLK_I);
            if (b < 2) rx_buf[b][i] = DOUT_OE_I ? DOUT_I : 1'bx;
            SCLK_O <= 1'b1;
            repeat (4) @(posedge CLK_I);
            SCLK_O <= 1'b0;
         end
      end
      repeat (4) @(posedge CLK_I);
      CS_N_O <= 1'b1;
      DIN_O <= ~DIN_O;
      repeat (8) @(posedge CLK_I);
   endtask
endmodule // asf_host

// file: tb.sv
// Purpose: self-checking bench for asf_top
// Assumes: 20 MHz clock, host model on the serial port
// Notes:   analog core results are driven as constants, changed between conversions
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, cs_n, sclk, din, dout, dout_oe, cnv_n, eoc_n;
   logic        neg, diff, ctemp, track, osc_en;
   logic [11:0] code, temp;
   logic [3:0]  chan;
   int          error_cnt = 0;
   int          cmp_count = 0;
   // ****************************************
   // harness
   // ****************************************
   asf_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCLK_I(sclk), .DIN_I(din),
      .DOUT_O(dout), .DOUT_OE_O(dout_oe), .CONVERSION_START_PIN_N_I(cnv_n), .EOC_N_O(eoc_n),
      .ANALOG_CODE_I(code), .ANALOG_NEG_I(neg), .TEMP_CODE_I(temp), .CONV_CHAN_O(chan),
      .CONV_DIFF_O(diff), .CONV_TEMP_O(ctemp), .TRACK_O(track), .OSC_EN_O(osc_en));
   asf_host i_host (.CLK_I(clk), .CS_N_O(cs_n), .SCLK_O(sclk), .DIN_O(din), .DOUT_I(dout),
      .DOUT_OE_I(dout_oe));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_eoc();
      int n;
      n = 0;
      while (eoc_n !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      chk("eoc", 16'h0000, {15'h0, eoc_n});
   endtask
   task automatic rd(input logic [11:0] e);
      i_host.frame(8'h00, 8'h00, 2);
      chk("result", {4'h0, e}, {i_host.rx_buf[0], i_host.rx_buf[1]});
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_serial();
      i_host.frame(8'h96, 8'h00, 1);
      wait_eoc();
      rd(12'hA5C);
      rd(12'h000);
      temp <= 12'hF38;
      i_host.frame(8'h87, 8'h00, 1);
      wait_eoc();
      rd(12'hF38);
      rd(12'hA5C);
   endtask
   task automatic t_fifo();
      i_host.frame(8'hF8, 8'h00, 1);
      wait_eoc();
      code <= 12'h3C1;
      i_host.frame(8'h96, 8'h00, 1);
      wait_eoc();
      for (int k = 0; k < 15; k++) rd(12'hA5C);
      rd(12'h3C1);
      rd(12'h000);
   endtask
   task automatic t_pairs();
      i_host.frame(8'h63, 8'h80, 2);
      i_host.frame(8'h86, 8'h00, 1);
      wait_eoc();
      rd(12'hBC1);
      i_host.frame(8'h63, 8'h00, 2);
      i_host.frame(8'h62, 8'h80, 2);
      neg <= 1'b1;
      i_host.frame(8'h86, 8'h00, 1);
      wait_eoc();
      rd(12'h000);
      neg <= 1'b0;
   endtask
   task automatic t_pin();
      i_host.frame(8'h10, 8'h00, 1);
      i_host.frame(8'h40, 8'h00, 1);
      i_host.frame(8'h9E, 8'h00, 1);
      repeat (200) @(posedge clk);
      chk("eoc idle", 16'h0001, {15'h0, eoc_n});
      cnv_n <= 1'b0;
      repeat (4) @(posedge clk);
      cnv_n <= 1'b1;
      wait_eoc();
      rd(12'h3C1);
      i_host.frame(8'h50, 8'h00, 1);
      for (int k = 0; k < 2; k++) begin
         cnv_n <= 1'b0;
         repeat (20) @(posedge clk);
         chk("track", 16'h0001, {15'h0, track});
         chk("chan", 16'h0003, {12'h0, chan});
         chk("eoc high", 16'h0001, {15'h0, eoc_n});
         chk("diff", 16'h0000, {15'h0, diff});
         chk("ctemp", 16'h0000, {15'h0, ctemp});
         cnv_n <= 1'b1;
         wait_eoc();
      end
      rd(12'h3C1);
      rd(12'h3C1);
      i_host.frame(8'h70, 8'h00, 1);
      repeat (2) @(posedge clk);
      chk("osc", 16'h0000, {15'h0, osc_en});
      chk("eoc ext", 16'h0001, {15'h0, eoc_n});
      i_host.frame(8'h86, 8'h00, 3);
      chk("eoc ext done", 16'h0001, {15'h0, eoc_n});
      rd(12'h3C1);
   endtask
   initial begin
      rst_n = 1'b0;
      cnv_n = 1'b1;
      neg = 1'b0;
      code = 12'hA5C;
      temp = 12'h000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("oe", 16'h0000, {15'h0, dout_oe});
      chk("osc rst", 16'h0001, {15'h0, osc_en});
      t_serial();
      t_fifo();
      t_pairs();
      t_pin();
      summarize();
   end
   initial begin
      #2_000_000;
      error_cnt++;
      summarize();
   end
endmodule // tb
bind asf_top asf_properties i_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .SCLK_I(SCLK_I),
   .CONVERSION_START_PIN_N_I(CONVERSION_START_PIN_N_I), .DOUT_O(DOUT_O), .DOUT_OE_O(DOUT_OE_O),
   .EOC_N_O(EOC_N_O), .CONV_CHAN_O(CONV_CHAN_O), .CONV_DIFF_O(CONV_DIFF_O), .TRACK_O(TRACK_O),
   .OSC_EN_O(OSC_EN_O));
